// ### design/sink_input_unit.sv
// Eight-channel sinking input unit with filter, input image and lamps
// How it works
// - A channel reads one when its terminal is pulled to ground.
// - Eight channels fill one byte at offset zero, bit n is channel n.
// - A rise to one is reported only after the active level held for 3 ms.
// - A fall to zero shows only after the inactive level held for 3 ms.
// - The unit takes no output bytes and ignores any output data offered.
// - There are no parameter bytes, no diagnostic bytes and no interrupts.
// - Bus fine with a module error lights fault, and run while the electronic supply is on.
// - Bus lost with a module error darkens run and lights fault.
// - A bus power fault darkens both run and fault.
// - A configuration error blinks the fault lamp at 2 Hz while bus power is good.
// - Each channel lamp follows its channel's reported state.
// - Channel lamps keep following inputs with the electronic supply off.
`include "sink_input_map.svh"

module sink_input_unit #(
    parameter int CHANNELS = 8,
    parameter int FILTER_CYCLES = `FILTER_CYCLES,
    parameter int BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [CHANNELS-1:0] channel_input_n,
    input wire logic [7:0] read_addr,
    input wire logic [7:0] output_data,
    input wire logic output_data_valid,
    input wire logic bus_ok,
    input wire logic bus_power_ok,
    input wire logic module_error,
    input wire logic config_error,
    input wire logic electronics_on,
    output logic [7:0] input_image_byte,
    output logic run_lamp,
    output logic fault_lamp,
    output logic [CHANNELS-1:0] channel_lamp
);
    localparam int CW = $clog2(FILTER_CYCLES + 1);
    localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);
    localparam logic [CW-1:0] FILTER_LAST = CW'(FILTER_CYCLES - 1);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYCLES - 1);

    logic [CHANNELS-1:0] sync1;
    logic [CHANNELS-1:0] next_sync1;
    logic [CHANNELS-1:0] sync2;
    logic [CHANNELS-1:0] next_sync2;
    logic [CHANNELS-1:0] sampled;
    logic [CHANNELS-1:0] next_sampled;
    logic [CHANNELS-1:0] filtered;
    logic [CHANNELS-1:0] next_filtered;
    logic [CW-1:0] count [CHANNELS];
    logic [CW-1:0] next_count [CHANNELS];
    logic [BW-1:0] blink_count;
    logic [BW-1:0] next_blink_count;
    logic blink;
    logic next_blink;
    logic [7:0] next_image;
    logic next_run;
    logic next_fault;
    logic [CHANNELS-1:0] next_lamp;
    sink_input_pkg::lamp_mode_t mode;

    // Output data and its strobe are deliberately left unused
    logic unused_out;
    assign unused_out = ^{output_data, output_data_valid};

    // Ground at the terminal reads as active; two flops for metastability
    always_comb begin
        next_sync1 = ~channel_input_n;
        next_sync2 = sync1;
        next_sampled = sync2;
    end

    // Reset leaves every channel reading inactive, so no false edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= '0;
            sync2 <= '0;
            sampled <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sampled <= next_sampled;
        end
    end

    // One filter per channel, each with its own counter
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_filter
            always_comb begin
                next_count[g] = count[g];
                next_filtered[g] = filtered[g];
                // A bounce restarts the count
                if (sync2[g] != sampled[g]) begin
                    next_count[g] = '0;
                end else if (sampled[g] != filtered[g]) begin
                    if (count[g] == FILTER_LAST) begin
                        next_filtered[g] = sampled[g];
                        next_count[g] = '0;
                    end else begin
                        next_count[g] = count[g] + CW'(1);
                    end
                end else begin
                    next_count[g] = '0;
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    count[g] <= '0;
                    filtered[g] <= 1'b0;
                end else begin
                    count[g] <= next_count[g];
                    filtered[g] <= next_filtered[g];
                end
            end
        end
    endgenerate

    // Only offset zero holds data; everything else reads zero
    always_comb begin
        next_image = '0;
        if (read_addr == `INPUT_IMAGE_OFFSET) begin
            next_image[CHANNELS-1:0] = filtered;
        end
    end

    // Registered so the byte stands steady between edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            input_image_byte <= `INPUT_IMAGE_RESET;
        end else begin
            input_image_byte <= next_image;
        end
    end

    // Free-running, so the blink phase does not wait for the error
    always_comb begin
        next_blink_count = blink_count + BW'(1);
        next_blink = blink;
        if (blink_count == BLINK_LAST) begin
            next_blink_count = '0;
            next_blink = ~blink;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blink_count <= '0;
            blink <= 1'b0;
        end else begin
            blink_count <= next_blink_count;
            blink <= next_blink;
        end
    end

    // Power loss outranks a lost bus, which outranks module status
    always_comb begin
        if (!bus_power_ok) begin
            mode = sink_input_pkg::lamp_power_fail;
        end else if (!bus_ok) begin
            mode = sink_input_pkg::lamp_bus_lost;
        end else begin
            mode = sink_input_pkg::lamp_normal;
        end
    end

    // Channel lamps run from the field side, so the electronics switch
    // does not gate them
    always_comb begin
        next_lamp = filtered;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channel_lamp <= '0;
        end else begin
            channel_lamp <= next_lamp;
        end
    end

    // Electronics off darkens only the run lamp
    always_comb begin
        next_run = 1'b0;
        next_fault = 1'b0;
        unique case (mode)
            sink_input_pkg::lamp_normal: begin
                next_run = 1'b1;
                next_fault = module_error;
            end
            sink_input_pkg::lamp_bus_lost: begin
                next_run = 1'b0;
                next_fault = 1'b1;
            end
            sink_input_pkg::lamp_power_fail: begin
                next_run = 1'b0;
                next_fault = 1'b0;
            end
        endcase
        if (config_error && mode != sink_input_pkg::lamp_power_fail) begin
            next_fault = blink;
        end
        if (!electronics_on) begin
            next_run = 1'b0;
        end
    end

    // No interrupt or diagnostic output exists by design
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_lamp <= 1'b0;
            fault_lamp <= 1'b0;
        end else begin
            run_lamp <= next_run;
            fault_lamp <= next_fault;
        end
    end
endmodule : sink_input_unit

// ### include/sink_input_map.svh
// Offsets, reset values and timing counts for the sinking input unit
`ifndef SINK_INPUT_MAP_SVH
`define SINK_INPUT_MAP_SVH
`define INPUT_IMAGE_OFFSET 8'h00
`define INPUT_IMAGE_RESET 8'h00
`define CLK_HZ 25000000
`define FILTER_DELAY_US 3000
`define FILTER_CYCLES ((`CLK_HZ / 1000000) * `FILTER_DELAY_US)
`define BLINK_HZ 2
`define BLINK_HALF_CYCLES (`CLK_HZ / (2 * `BLINK_HZ))
`endif

// ### include/sink_input_pkg.sv
// Types for the sinking input unit
package sink_input_pkg;
    typedef enum logic [1:0] {
        lamp_normal,
        lamp_bus_lost,
        lamp_power_fail
    } lamp_mode_t;
endpackage : sink_input_pkg

// ### tb/bus_master_model.sv
// Far-side master offering output data
module bus_master_model (
    input wire logic clk,
    output logic [7:0] output_data = 8'h00,
    output logic output_data_valid = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Data changes every cycle and valid toggles, so data is offered every second cycle and any use of it shows in the image
    always @(posedge clk) begin
        output_data <= #1 output_data + 8'h3b;
        output_data_valid <= #1 ~output_data_valid;
    end
endmodule : bus_master_model

// ### tb/sink_input_props.sv
// Checker for the sinking input unit
module sink_input_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] channel_input_n,
    input wire logic [7:0] read_addr,
    input wire logic bus_ok,
    input wire logic bus_power_ok,
    input wire logic module_error,
    input wire logic config_error,
    input wire logic [7:0] input_image_byte,
    input wire logic run_lamp,
    input wire logic fault_lamp,
    input wire logic [7:0] channel_lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic pw;
    assign pw = bus_power_ok && !config_error;
    AST_UNMAPPED: assert property (read_addr != 8'h00 |=>
        input_image_byte == 8'h00) else $error("unmapped read");
    AST_LAMPS: assert property (read_addr == 8'h00 |=>
        channel_lamp == input_image_byte) else $error("lamps");
    AST_PWR: assert property (!bus_power_ok |=>
        !run_lamp && !fault_lamp) else $error("power lamps");
    AST_LOST: assert property (pw && !bus_ok |=>
        !run_lamp && fault_lamp) else $error("bus lost lamps");
    AST_ERR: assert property (pw && bus_ok |=>
        fault_lamp == $past(module_error)) else $error("error lamp");
    AST_RISE: assert property ($rose(channel_lamp[0]) |->
        !$past(channel_input_n[0], 8)) else $error("early rise");
    AST_FALL: assert property ($fell(channel_lamp[0]) |->
        $past(channel_input_n[0], 8)) else $error("early fall");
    AST_BLINK: assert property ((bus_power_ok && config_error
        && $stable(fault_lamp))[*5] |=> !(bus_power_ok && config_error)
        || $changed(fault_lamp)) else $error("no blink");
endmodule : sink_input_props
bind sink_input_unit sink_input_props chk (.*);

// ### tb/sink_input_unit_tb.sv
// Self-checking bench for the sinking input unit
module sink_input_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, bok = 1'b1, pok = 1'b1, err = 1'b0;
    logic cfg = 1'b0, eon = 1'b1, odv, run, flt, pf;
    logic [7:0] cin = 8'hff, ra = 8'h00, od, img, lamps;
    int fail_count = 0, n_checks = 0, cycles = 0, tg = 0;
    `define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
      fail_count++; $display("wrong value %s %h %h", n, e, g); end end
    always #20 clk = ~clk;
    // Whole run is about 90 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    bus_master_model partner (.clk(clk), .output_data(od),
        .output_data_valid(odv));
    sink_input_unit #(.FILTER_CYCLES(8), .BLINK_HALF_CYCLES(4)) dut (
        .clk(clk), .rstn(rstn), .channel_input_n(cin), .read_addr(ra),
        .output_data(od), .output_data_valid(odv), .bus_ok(bok),
        .bus_power_ok(pok), .module_error(err), .config_error(cfg),
        .electronics_on(eon), .input_image_byte(img), .run_lamp(run),
        .fault_lamp(flt), .channel_lamp(lamps));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        ra = a;
        step(1);
        `CHK("image", e, img)
    endtask : rd
    task automatic lamp(input logic [2:0] s, input logic [1:0] e);
        {pok, bok, err} = s;
        step(2);
        `CHK("run_fault", e, {run, flt})
    endtask : lamp
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        step(12);
        rstn = 1'b1;
        rd(8'h00, 8'h00);
        cin = ~8'ha5;
        step(6);
        rd(8'h00, 8'h00);
        step(6);
        rd(8'h00, 8'ha5);
        rd(8'h01, 8'h00);
        `CHK("lamps", 8'ha5, lamps)
        cin = 8'hff;
        step(6);
        rd(8'h00, 8'ha5);
        eon = 1'b0;
        step(8);
        rd(8'h00, 8'h00);
        cin = 8'hf0;
        step(14);
        `CHK("lamps_off", 8'h0f, lamps)
        eon = 1'b1;
        lamp(3'b110, 2'b10);
        lamp(3'b111, 2'b11);
        lamp(3'b101, 2'b01);
        lamp(3'b011, 2'b00);
        lamp(3'b110, 2'b10);
        cfg = 1'b1;
        step(2);
        repeat (16) begin
            pf = flt;
            step(1);
            if (flt !== pf) tg++;
        end
        `CHK("blink", 4, tg)
        tally_and_finish();
    end
endmodule : sink_input_unit_tb
